//--- src/sstx_map.vh
// Purpose: Register map and field layout of the secondary port channel 6-8 routing
// Assumes: Registers sit at byte address four times their index
// Notes:   Definitions only
`ifndef SSTX_MAP_VH
`define SSTX_MAP_VH
// Register indices and byte addresses
`define SSTX_IDX_CH6        8'h23
`define SSTX_IDX_CH7        8'h24
`define SSTX_IDX_CH8        8'h25
`define SSTX_IDX_CTRL       8'h28
`define SSTX_ADDR_CH6       10'h08c
`define SSTX_ADDR_CH7       10'h090
`define SSTX_ADDR_CH8       10'h094
`define SSTX_ADDR_CTRL      10'h0a0
// Reset values
`define SSTX_RST_CH6        8'h05
`define SSTX_RST_CH7        8'h06
`define SSTX_RST_CH8        8'h07
`define SSTX_RST_CTRL       8'h00
// Fields
`define SSTX_SRC_HI         6
`define SSTX_SRC_LO         5
`define SSTX_SLOT_HI        4
`define SSTX_SLOT_LO        0
`define SSTX_CTRL_I2S       0
`define SSTX_CTRL_WL_HI     2
`define SSTX_CTRL_WL_LO     1
// Source selections
`define SSTX_SRC_HIZ        2'h0
`define SSTX_SRC_LOOP       2'h1
`define SSTX_SRC_ECHO       2'h2
// Slot numbering
`define SSTX_RIGHT_BASE     5'h10
`endif

//--- src/sstx_skid_buffer.v
// Purpose: Two-entry valid/ready buffer
// Assumes: One clock, asynchronous active-high reset
// Notes:   Full registered; no bubble between words
`timescale 1ns/100ps
module sstx_skid_buffer #(
   parameter WIDTH = 32
) (
   // Clock and reset
   input  wire             sysClk,
   input  wire             reset,
   // Fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // Drain side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem_q [0:1];
   reg             wrPtr_q;
   reg             rdPtr_q;
   reg [1:0]       count_q;
   wire            push;
   wire            pop;

   assign inReady  = (count_q != 2'h2);
   assign outValid = (count_q != 2'h0);
   assign outData  = mem_q[rdPtr_q];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         mem_q[0] <= {WIDTH{1'b0}};
         mem_q[1] <= {WIDTH{1'b0}};
         wrPtr_q  <= 1'b0;
         rdPtr_q  <= 1'b0;
         count_q  <= 2'h0;
      end else begin
         if (push) begin
            mem_q[wrPtr_q] <= inData;
            wrPtr_q        <= ~wrPtr_q;
         end
         if (pop)
            rdPtr_q <= ~rdPtr_q;
         if (push & ~pop)
            count_q <= count_q + 2'h1;
         else if (pop & ~push)
            count_q <= count_q - 2'h1;
      end
   end
endmodule

//--- src/sstx_channel_router.v
// Purpose: Source selection and slot placement of secondary port output channels 6, 7, 8
// Assumes: Bit clock and frame sync are pins from another domain, oversampled by sysClk
// Notes:   Frame sync rising edge marks slot 0 (TDM) or the left half (I2S/LJ)
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "sstx_map.vh"
module sstx_channel_router #(
   parameter WORD_BITS = 32
) (
   // Clock and reset
   input  wire                 sysClk,
   input  wire                 reset,
   // AXI4-Lite write address
   input  wire [9:0]           s_axi_awaddr,
   input  wire                 s_axi_awvalid,
   output wire                 s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   input  wire                 s_axi_wvalid,
   output wire                 s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]           s_axi_bresp,
   output reg                  s_axi_bvalid,
   input  wire                 s_axi_bready,
   // AXI4-Lite read address
   input  wire [9:0]           s_axi_araddr,
   input  wire                 s_axi_arvalid,
   output wire                 s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0]          s_axi_rdata,
   output reg  [1:0]           s_axi_rresp,
   output reg                  s_axi_rvalid,
   input  wire                 s_axi_rready,
   // Serial link pins
   input  wire                 bitClk,
   input  wire                 frameSync,
   output reg                  serialOut,
   output reg                  serialOutEn,
   // Sample sources, one word per frame
   input  wire                 srcValid,
   output wire                 srcReady,
   input  wire [WORD_BITS-1:0] loopbackIn2,
   input  wire [WORD_BITS-1:0] echoReference2,
   input  wire [WORD_BITS/2-1:0] echoReference1HalfWord,
   input  wire [WORD_BITS/2-1:0] echoReference2HalfWord,
   input  wire [WORD_BITS-1:0] chipLinkAggregateData
);
   localparam BUF_W = 4 * WORD_BITS;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg  [7:0]  ch6_q;
   reg  [7:0]  ch7_q;
   reg  [7:0]  ch8_q;
   reg  [7:0]  ctrl_q;
   reg         awHeld_q;
   reg  [9:0]  awAddr_q;
   reg         wHeld_q;
   reg  [31:0] wData_q;
   reg  [3:0]  wStrb_q;
   wire        doWrite;
   reg         wrHit;

   assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
   assign doWrite       = awHeld_q & wHeld_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always @* begin
      case (awAddr_q)
         `SSTX_ADDR_CH6, `SSTX_ADDR_CH7, `SSTX_ADDR_CH8, `SSTX_ADDR_CTRL: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         ch6_q        <= `SSTX_RST_CH6;
         ch7_q        <= `SSTX_RST_CH7;
         ch8_q        <= `SSTX_RST_CH8;
         ctrl_q       <= `SSTX_RST_CTRL;
         awHeld_q     <= 1'b0;
         awAddr_q     <= 10'h000;
         wHeld_q      <= 1'b0;
         wData_q      <= 32'h00000000;
         wStrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[9:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? 2'h0 : 2'h2;
            if (wStrb_q[0]) begin
               case (awAddr_q)
                  `SSTX_ADDR_CH6:  ch6_q  <= {1'b0, wData_q[6:0]};
                  `SSTX_ADDR_CH7:  ch7_q  <= {1'b0, wData_q[6:0]};
                  `SSTX_ADDR_CH8:  ch8_q  <= {2'b00, wData_q[5:0]};
                  `SSTX_ADDR_CTRL: ctrl_q <= {5'h00, wData_q[2:0]};
                  default:         ctrl_q <= ctrl_q;
               endcase
            end
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel; status register shows slot position and buffer state
   reg [7:0] slotNow_q;
   reg       bufFull;

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         case ({s_axi_araddr[9:2], 2'b00})
            `SSTX_ADDR_CH6:  s_axi_rdata <= {24'h000000, ch6_q};
            `SSTX_ADDR_CH7:  s_axi_rdata <= {24'h000000, ch7_q};
            `SSTX_ADDR_CH8:  s_axi_rdata <= {24'h000000, ch8_q};
            `SSTX_ADDR_CTRL: s_axi_rdata <= {15'h0000, bufFull, slotNow_q, 5'h00, ctrl_q[2:0]};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------------------------------
   reg [1:0] bclkSync_q;
   reg [1:0] fsSync_q;
   reg       bclkLast_q;
   reg       fsLast_q;
   wire      bclkRise;
   wire      bclkFall;

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         bclkSync_q <= 2'b00;
         fsSync_q   <= 2'b00;
         bclkLast_q <= 1'b0;
         fsLast_q   <= 1'b0;
      end else begin
         bclkSync_q <= {bclkSync_q[0], bitClk};
         fsSync_q   <= {fsSync_q[0], frameSync};
         bclkLast_q <= bclkSync_q[1];
         if (bclkRise)
            fsLast_q <= fsSync_q[1];
      end
   end

   assign bclkRise = bclkSync_q[1] & ~bclkLast_q;
   assign bclkFall = ~bclkSync_q[1] & bclkLast_q;

   // ----------------------------------------------------------------
   // Sample buffer: a stalled frame keeps its words
   // ----------------------------------------------------------------
   wire [BUF_W-1:0] bufOut;
   wire             bufValid;
   wire             bufReady;
   wire             frameStart;
   reg  [BUF_W-1:0] frame_q;

   sstx_skid_buffer #(.WIDTH(BUF_W)) u_buf (
      .sysClk   (sysClk),
      .reset    (reset),
      .inValid  (srcValid),
      .inReady  (srcReady),
      .inData   ({chipLinkAggregateData, echoReference1HalfWord, echoReference2HalfWord,
                  echoReference2, loopbackIn2}),
      .outValid (bufValid),
      .outReady (bufReady),
      .outData  (bufOut)
   );

   always @* bufFull = ~srcReady;

   // Frame sync sampled on rising bit clock; a new frame takes one word
   assign frameStart = bclkRise & fsSync_q[1] & ~fsLast_q;
   assign bufReady   = frameStart;

   // ----------------------------------------------------------------
   // Slot timing
   // ----------------------------------------------------------------
   reg  [7:0]  bitCnt_q;
   reg  [7:0]  slotIdx_q;
   reg  [4:0]  bitInSlot_q;
   wire [4:0]  wordTop;
   wire        lrMode;

   assign lrMode  = ctrl_q[`SSTX_CTRL_I2S];
   // Word length: 16, 20, 24 or 32 bits, from ctrl bits 2:1 alone
   assign wordTop = (ctrl_q[`SSTX_CTRL_WL_HI:`SSTX_CTRL_WL_LO] == 2'h0) ? 5'd15 :
                    (ctrl_q[`SSTX_CTRL_WL_HI:`SSTX_CTRL_WL_LO] == 2'h1) ? 5'd19 :
                    (ctrl_q[`SSTX_CTRL_WL_HI:`SSTX_CTRL_WL_LO] == 2'h2) ? 5'd23 : 5'd31;

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         bitCnt_q    <= 8'h00;
         slotIdx_q   <= 8'h00;
         bitInSlot_q <= 5'h00;
         frame_q     <= {BUF_W{1'b0}};
         slotNow_q   <= 8'h00;
      end else if (bclkRise) begin
         if (frameStart) begin
            bitCnt_q    <= 8'h00;
            slotIdx_q   <= 8'h00;
            bitInSlot_q <= 5'h00;
            if (bufValid)
               frame_q <= bufOut;
         end else if (bitInSlot_q == wordTop) begin
            bitInSlot_q <= 5'h00;
            slotIdx_q   <= slotIdx_q + 8'h01;
            bitCnt_q    <= bitCnt_q + 8'h01;
         end else begin
            bitInSlot_q <= bitInSlot_q + 5'h01;
            bitCnt_q    <= bitCnt_q + 8'h01;
         end
         slotNow_q <= slotIdx_q;
      end
   end

   // In I2S/LJ the right half starts when frame sync falls
   reg        rightHalf_q;
   reg  [7:0] lrSlot_q;

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         rightHalf_q <= 1'b0;
         lrSlot_q    <= 8'h00;
      end else if (bclkRise) begin
         if (frameStart) begin
            rightHalf_q <= 1'b0;
            lrSlot_q    <= 8'h00;
         end else if (~fsSync_q[1] & fsLast_q) begin
            rightHalf_q <= 1'b1;
            lrSlot_q    <= 8'h00;
         end else if (bitInSlot_q == wordTop) begin
            lrSlot_q <= lrSlot_q + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Per-channel source and slot match
   // ----------------------------------------------------------------
   wire [2:0]           chanActive;
   wire [2:0]           chanHit;
   wire [WORD_BITS-1:0] chanWord [0:2];
   wire [7:0]           cfgOf [0:2];

   assign cfgOf[0] = ch6_q;
   assign cfgOf[1] = ch7_q;
   assign cfgOf[2] = ch8_q;

   assign chanActive[0] = (ch6_q[`SSTX_SRC_HI:`SSTX_SRC_LO] == `SSTX_SRC_LOOP) |
                          (ch6_q[`SSTX_SRC_HI:`SSTX_SRC_LO] == `SSTX_SRC_ECHO);
   assign chanActive[1] = (ch7_q[`SSTX_SRC_HI:`SSTX_SRC_LO] == `SSTX_SRC_ECHO);
   assign chanActive[2] = ch8_q[`SSTX_SRC_LO];

   // Reserved codes leave the channel released
   assign chanWord[0] = (ch6_q[`SSTX_SRC_HI:`SSTX_SRC_LO] == `SSTX_SRC_LOOP) ?
                        frame_q[WORD_BITS-1:0] : frame_q[2*WORD_BITS-1:WORD_BITS];
   assign chanWord[1] = frame_q[3*WORD_BITS-1:2*WORD_BITS];
   assign chanWord[2] = frame_q[4*WORD_BITS-1:3*WORD_BITS];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gSlot
         wire [4:0] sl = cfgOf[g][`SSTX_SLOT_HI:`SSTX_SLOT_LO];
         // TDM counts slots from frame start; I2S/LJ splits at 16
         assign chanHit[g] = lrMode ?
            ((sl[4] == rightHalf_q) && (lrSlot_q == {4'h0, sl[3:0]})) :
            (slotIdx_q == {3'h0, sl});
      end
   endgenerate

   // ----------------------------------------------------------------
   // Output drive, updated on falling bit clock, MSB first
   // ----------------------------------------------------------------
   reg [WORD_BITS-1:0] selWord;
   reg                 selOn;

   always @* begin
      selOn   = 1'b0;
      selWord = {WORD_BITS{1'b0}};
      if (chanActive[0] & chanHit[0]) begin
         selOn   = 1'b1;
         selWord = chanWord[0];
      end else if (chanActive[1] & chanHit[1]) begin
         selOn   = 1'b1;
         selWord = chanWord[1];
      end else if (chanActive[2] & chanHit[2]) begin
         selOn   = 1'b1;
         selWord = chanWord[2];
      end
   end

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         serialOut   <= 1'b0;
         serialOutEn <= 1'b0;
      end else if (bclkFall) begin
         serialOutEn <= selOn;
         serialOut   <= selOn & selWord[wordTop - bitInSlot_q];
      end
   end
endmodule

//--- tb/sstx_props.sv
// Purpose: Bus and serial line checks of the channel 6-8 router
// Assumes: Shadow registers follow completed bus writes
// Notes:   Released line is judged only after a quiet spell
`timescale 1ns/100ps
`include "sstx_map.vh"
module sstx_props (
   // Clock and reset
   input wire logic        sysClk,
   input wire logic        reset,
   // Bus
   input wire logic [9:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [9:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   // Serial line
   input wire logic        bitClk,
   input wire logic        serialOut,
   input wire logic        serialOutEn
);
   default clocking cb @(posedge sysClk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Shadow registers
   // ----------------------------------------
   logic [9:0] wa, ra;
   logic [7:0] wd, sh6, sh7, sh8;
   logic [4:0] offCnt;
   wire awHs = s_axi_awvalid && s_axi_awready;
   wire wHs = s_axi_wvalid && s_axi_wready;
   wire allOff = sh6[6:5] != 2'h1 && sh6[6:5] != 2'h2 && sh7[6:5] != 2'h2 && !sh8[5];
   wire mapped = wa == `SSTX_ADDR_CH6 || wa == `SSTX_ADDR_CH7 || wa == `SSTX_ADDR_CH8
                 || wa == `SSTX_ADDR_CTRL;
   always_ff @(posedge sysClk or posedge reset) begin
      if (reset) begin
         sh6 <= `SSTX_RST_CH6;
         sh7 <= `SSTX_RST_CH7;
         sh8 <= `SSTX_RST_CH8;
         offCnt <= 5'h00;
         wa <= 10'h000;
         wd <= 8'h00;
         ra <= 10'h000;
      end else begin
         if (awHs) wa <= s_axi_awaddr;
         if (wHs) wd <= s_axi_wdata[7:0];
         if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
         if (s_axi_bvalid && s_axi_bready && wa == `SSTX_ADDR_CH6) sh6 <= wd & 8'h7f;
         if (s_axi_bvalid && s_axi_bready && wa == `SSTX_ADDR_CH7) sh7 <= wd & 8'h7f;
         if (s_axi_bvalid && s_axi_bready && wa == `SSTX_ADDR_CH8) sh8 <= wd & 8'h3f;
         // Writes restart the spell: the new setting may only land at a bit clock edge
         if (!allOff || awHs || wHs) offCnt <= 5'h00;
         else if (offCnt != 5'h1f) offCnt <= offCnt + 5'h01;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_ch6_read; s_axi_rvalid && ra == `SSTX_ADDR_CH6 |-> s_axi_rdata == {24'h0, sh6}; endproperty
   a_ch6_read: assert property (p_ch6_read) else $error("channel 6 read mismatch");
   property p_ch7_read; s_axi_rvalid && ra == `SSTX_ADDR_CH7 |-> s_axi_rdata == {24'h0, sh7}; endproperty
   a_ch7_read: assert property (p_ch7_read) else $error("channel 7 read mismatch");
   property p_ch8_read; s_axi_rvalid && ra == `SSTX_ADDR_CH8 |-> s_axi_rdata == {24'h0, sh8}; endproperty
   a_ch8_read: assert property (p_ch8_read) else $error("channel 8 read mismatch");
   property p_released; offCnt >= 5'd20 |-> !serialOutEn; endproperty
   a_released: assert property (p_released) else $error("line driven with no source");
   property p_en_edge; $changed(serialOutEn) |-> $past(bitClk, 2) == 1'b0; endproperty
   a_en_edge: assert property (p_en_edge) else $error("enable moved off the falling edge");
   property p_out_edge; serialOutEn && $changed(serialOut) |-> $past(bitClk, 2) == 1'b0; endproperty
   a_out_edge: assert property (p_out_edge) else $error("data moved off the falling edge");
   property p_bresp; s_axi_bvalid |-> s_axi_bresp == (mapped ? 2'h0 : 2'h2); endproperty
   a_bresp: assert property (p_bresp) else $error("write response code wrong");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_arready; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arready: assert property (p_arready) else $error("read address taken while busy");
   property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bdone: assert property (p_bdone) else $error("write response repeated");
   c_drive: cover property (serialOutEn);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_ch8: cover property (s_axi_rvalid && ra == `SSTX_ADDR_CH8);
endmodule
bind sstx_channel_router sstx_props props_u (.*);

//--- tb/sstx_host_model.sv
// Purpose: Receiving host: makes bit clock and frame sync, captures one frame
// Assumes: Bit clock period 160 ns, stands still between frames
// Notes:   A released line shows the inverse of its last driven level
`timescale 1ns/100ps
module sstx_host_model (
   // Link pins made here
   output logic         bitClk,
   output logic         frameSync,
   // Data line from the device
   input  wire logic    serialOut,
   input  wire logic    serialOutEn,
   // Frame just received
   output logic [255:0] rxData,
   output logic [255:0] rxEn
);
   logic lastBit = 1'b0;
   wire  line = serialOutEn ? serialOut : ~lastBit;
   always @(serialOut or serialOutEn) if (serialOutEn) lastBit = serialOut;
   initial begin
      bitClk = 1'b0;
      frameSync = 1'b0;
   end
   // Bit i is sampled late in the high phase after it was launched
   task automatic frame(input int nBits, input int syncBits);
      rxData = '0;
      rxEn = '0;
      for (int i = 0; i <= nBits; i++) begin
         frameSync = (i < syncBits);
         #40 bitClk = 1'b1;
         #79 if (i > 0) begin
            rxData[i-1] = line;
            rxEn[i-1] = serialOutEn;
         end
         #1 bitClk = 1'b0;
         #40;
      end
   endtask
endmodule

//--- tb/sec_serial_tx_ch6_8_routing_bench.sv
// Purpose: Register, buffer and slot placement tests of the channel 6-8 router
// Assumes: Bus tasks sample ready at the rising sysClk edge that takes the request
// Notes:   Words change only between frames, with the bit clock still
`timescale 1ns/100ps
`include "sstx_map.vh"
module sec_serial_tx_ch6_8_routing_bench;
   logic        sysClk = 0, reset = 1, srcValid = 0, srcReady, r, on;
   logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, bitClk, frameSync, serialOut, serialOutEn;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, p, word;
   logic [31:0] loopbackIn2 = 0, echoReference2 = 0, chipLinkAggregateData = 0;
   logic [15:0] echoReference1HalfWord = 0, echoReference2HalfWord = 0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0]  g;
   logic [255:0] rxData, rxEn, expD, expE;
   logic [31:0] plan [5] = '{32'h06214325, 32'h06410322, 32'h06612307, 32'h06226222, 32'h07300020};
   int          fail_count = 0, checked = 0, cycles = 0, k, s, pos, wk;
   sstx_channel_router dut_u (.*, .s_axi_wstrb(4'hf));
   sstx_host_model host_u (.*);
   initial forever #10 sysClk = ~sysClk;
   always @(posedge sysClk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [255:0] exp, seen);
      checked++;
      if (exp !== seen) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic setw(input int n);
      loopbackIn2 <= 32'h11110000 + n;
      echoReference2 <= 32'h22220000 + n;
      echoReference1HalfWord <= 16'(16'h3300 + n);
      echoReference2HalfWord <= 16'(16'h4400 + n);
      chipLinkAggregateData <= 32'h55550000 + n;
   endtask
   task automatic axi(input bit wr, input logic [9:0] a, input logic [31:0] d);
      bit aw, w, done;
      @(posedge sysClk);
      aw = wr;
      w = wr;
      done = 0;
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1;
         s_axi_wvalid <= 1;
         s_axi_bready <= 1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1;
         s_axi_rready <= 1;
      end
      // Only the bench timeout ends a wait for the answer
      while (!done) begin
         @(posedge sysClk);
         if (aw && s_axi_awready) begin
            aw = 0;
            s_axi_awvalid <= 0;
         end
         if (w && s_axi_wready) begin
            w = 0;
            s_axi_wvalid <= 0;
         end
         if (!wr && s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         done = wr ? s_axi_bvalid : s_axi_rvalid;
         if (done) begin
            rd = s_axi_rdata;
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            s_axi_bready <= 0;
            s_axi_rready <= 0;
         end
      end
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge sysClk);
      reset <= 0;
      for (int c = 0; c < 3; c++) begin
         axi(0, 10'(`SSTX_ADDR_CH6 + 4 * c), 0);
         check("reset value", 8'h05 + c, rd);
         axi(1, 10'(`SSTX_ADDR_CH6 + 4 * c), 32'(8'h7f >> (c / 2)));
         axi(0, 10'(`SSTX_ADDR_CH6 + 4 * c), 0);
         check("reserved bits", 8'h7f >> (c / 2), rd);
      end
      axi(1, 10'h3fc, 1);
      check("unmapped write", 2'h2, rsp);
      axi(0, 10'h3fc, 0);
      check("unmapped read", 2'h2, rsp);
      $display("test registers done");
      // Fill the buffer with no frames running, so nothing drains it
      k = 0;
      setw(0);
      srcValid <= 1;
      repeat (6) begin
         @(posedge sysClk);
         if (srcValid && srcReady) begin
            k++;
            setw(k);
         end else srcValid <= 0;
      end
      check("buffer depth", 2, k);
      axi(0, `SSTX_ADDR_CTRL, 0);
      check("buffer full flag", 1, rd[16]);
      $display("test buffer done");
      for (int f = 0; f < 5; f++) begin
         p = plan[f];
         for (int c = 0; c < 4; c++) axi(1, c ? 10'(`SSTX_ADDR_CH6 + 4 * (c - 1)) : `SSTX_ADDR_CTRL,
                                         32'(p[31-8*c -: 8]));
         host_u.frame(p[24] ? 64 : 256, p[24] ? 32 : 1);
         wk = f ? 1 : 0;
         expD = '0;
         expE = '0;
         // Channel 6 goes last so it wins any overlap
         for (int c = 2; c >= 0; c--) begin
            g = p[23-8*c -: 8];
            case (c)
               0: begin
                  on = g[6:5] == 2'h1 || g[6:5] == 2'h2;
                  word = g[6:5] == 2'h1 ? 32'h11110000 + wk : 32'h22220000 + wk;
               end
               1: begin
                  on = g[6:5] == 2'h2;
                  word = {16'(16'h3300 + wk), 16'(16'h4400 + wk)};
               end
               default: begin
                  on = g[5];
                  word = 32'h55550000 + wk;
               end
            endcase
            s = g[4:0];
            pos = (p[24] && s >= 16) ? 32 + (s - 16) * 32 : s * 32;
            if (on) for (int b = 0; b < 32; b++) begin
               expD[pos+b] = word[31-b];
               expE[pos+b] = 1'b1;
            end
         end
         check("slot enables", expE, rxEn);
         check("slot data", expD, rxData & expE);
         $display("test frame %0d done", f);
      end
      axi(0, `SSTX_ADDR_CTRL, 0);
      check("buffer drained", 0, rd[16]);
      end_of_test();
   end
endmodule
